// >>> logic/sfw_pkg.sv
// Purpose: Shared constants and types of the serial flash command logic.
// Assumes: One ref_clk domain at 250 MHz and one serial clock domain.
// Notes:   Opcodes, field positions and reset values live here only.
`default_nettype none
package sfw_pkg;
  localparam int CLK_MHZ = 250;
  localparam logic [7:0] OP_WRAP = 8'h77;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_QRD  = 8'hEB;
  localparam logic [7:0] OP_QWRD = 8'hE7;
  localparam logic [7:0] OP_DRD  = 8'hBB;
  localparam logic [1:0] CTL_CONT = 2'h2;
  localparam int WRAP_LSB = 4;
  localparam int CTL_LSB = 4;
  localparam logic [2:0] WRAP_RST = 3'h1;
  localparam logic [10:0] DEV_SECTORS = 11'h400;
  localparam logic [7:0] WRAP_BASE = 8'h08;

  typedef enum logic [5:0] {
    ST_CMD  = 6'h01,
    ST_RDAD = 6'h02,
    ST_WRAP = 6'h04,
    ST_PADR = 6'h08,
    ST_PDAT = 6'h10,
    ST_SKIP = 6'h20
  } sfw_state_type;

  // Wrap setting as stored: length select above the disable bit.
  typedef struct packed {
    logic [1:0] len;
    logic       dis;
  } sfw_wrap_type;

  typedef struct packed {
    logic       cmp;
    logic       sec;
    logic       tb;
    logic [2:0] bp;
  } sfw_prot_type;

  typedef struct packed {
    logic        we;
    logic [23:0] addr;
    logic [7:0]  data;
  } sfw_prog_type;
endpackage : sfw_pkg
`default_nettype wire

// >>> logic/sfw_cmd_core.sv
// Purpose: Command decoder for wrap setup, continuous read and page program.
// Assumes: The serial clock runs only while chip select is low.
// Notes:   Eight serial edges form one group of all four IO lines.
//
// Overview of operation
// - Wrap setup: 77h, 24 ignored bits, byte
// - Only wrap setting bits 6..4 matter
// - Length select picks 8/16/32/64 byte section
// - Disable bit stops wrapping, resets to one
// - Wrap setting applies to later quad reads
// - Wrapped reads loop in section until deselect
// - Mode byte follows read address on IO
// - Mode pair 10 skips next frame opcode
// - Other mode pair restores normal opcode decoding
// - Reserved mode bits have no effect
// - All-ones reset forces release bit high
// - Continuous mode treats frame start as address
// - Reset: eight quad or sixteen dual clocks
// - Program 02h, address, 1..256 bytes single line
// - Program needs write enable latch set
// - Deselect off byte boundary discards program
// - Program byte address wraps within page
// - Self-timed cycle shows busy for program time
// - Write enable latch clears at cycle end
// - Protected page program is skipped
`default_nettype none
module sfw_cmd_core
  import sfw_pkg::*;
#(
  parameter int TPP_US = 1000
)(
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 spi_clk,
  input  wire logic                 cs_n,
  input  wire logic [3:0]           io_in,
  input  wire sfw_pkg::sfw_prot_type prot,
  input  wire logic                 rd_next,
  output logic [23:0]               read_addr,
  output logic                      read_active,
  output logic                      read_wrap_on,
  output logic [2:0]                wrap_config_field,
  output logic                      cont_read_on,
  output logic                      busy,
  output logic                      write_enable_latch,
  output sfw_pkg::sfw_prog_type     prog
);
  import sfw_pkg::*;

  localparam int TPP_CYC = TPP_US * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////
  // Serial clock domain: gather eight edges of all four lines.
  logic        first_r;
  logic [2:0]  cnt_r;
  logic [2:0]  cnt_nxt;
  logic [31:0] sh_r;
  logic [31:0] sh_nxt;
  logic [31:0] grp_r;
  logic [31:0] grp_nxt;
  logic        tog_r;
  logic        tog_nxt;
  logic        algn_r;

  // Chip select high re-arms the group counter for the next frame.
  always_ff @(posedge spi_clk or posedge cs_n)
  begin
    if (cs_n)
      first_r <= 1'b1;
    else
      first_r <= 1'b0;
  end

  // The counter is not cleared by deselect, so the last frame's
  // byte alignment is still readable after the clock stops.
  always_comb
  begin
    cnt_nxt = (first_r ? 3'h0 : cnt_r) + 3'h1;
    sh_nxt  = {sh_r[27:0], io_in};
    grp_nxt = grp_r;
    tog_nxt = tog_r;
    if (cnt_nxt == 3'h0)
    begin
      grp_nxt = sh_nxt;
      tog_nxt = ~tog_r;
    end
  end

  // The serial clock is parked during reset, so the group toggle is
  // cleared asynchronously; an unknown toggle would never resolve.
  always_ff @(posedge spi_clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_r  <= 3'h0;
      sh_r   <= 32'h00000000;
      grp_r  <= 32'h00000000;
      tog_r  <= 1'b0;
      algn_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      grp_r  <= grp_nxt;
      tog_r  <= tog_nxt;
      algn_r <= (cnt_nxt == 3'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Crossing into ref_clk: levels through two flops, group word held
  // stable for eight serial clocks after its toggle.
  logic cs_s1, cs_s2, cs_s3;
  logic tg_s1, tg_s2, tg_s3;
  logic al_s1, al_s2;
  logic end_d1, end_d2;

  always_ff @(posedge ref_clk)
  begin
    cs_s1  <= cs_n;
    cs_s2  <= cs_s1;
    cs_s3  <= cs_s2;
    tg_s1  <= tog_r;
    tg_s2  <= tg_s1;
    tg_s3  <= tg_s2;
    al_s1  <= algn_r;
    al_s2  <= al_s1;
    end_d1 <= cs_s2 & ~cs_s3;
    end_d2 <= end_d1;
  end

  logic fstart, gev;
  assign fstart = ~cs_s2 & cs_s3;
  assign gev    = tg_s2 ^ tg_s3;

  // Lane extraction of a group word for one and two line phases.
  function automatic logic [7:0] lane1(input logic [31:0] w);
    logic [7:0] b;
    b = 8'h00;
    for (int k = 0; k < 8; k++)
      b[k] = w[4*k];
    return b;
  endfunction : lane1

  function automatic logic [15:0] lane2(input logic [31:0] w);
    logic [15:0] d;
    d = 16'h0000;
    for (int k = 0; k < 8; k++)
      d[2*k +: 2] = w[4*k +: 2];
    return d;
  endfunction : lane2

  // Sector index against the block-protect region.
  function automatic logic prot_hit(input logic [9:0] s,
                                    input sfw_prot_type p);
    logic [10:0] n;
    logic        h;
    if (p.sec)
      n = 11'h001 << ((p.bp > 3'h4) ? 3'h3 : p.bp - 3'h1);
    else
      n = 11'h010 << (p.bp - 3'h1);
    if (p.bp == 3'h0)
      h = 1'b0;
    else if (p.tb)
      h = {1'b0, s} < n;
    else
      h = {1'b0, s} >= DEV_SECTORS - n;
    return h ^ p.cmp;
  endfunction : prot_hit

  ////////////////////////////////////////////////////////////////////
  // Frame decoder and program sequencer state.
  sfw_state_type st_r, st_nxt;
  logic [1:0]   gi_r, gi_nxt;
  logic [7:0]   op_r, op_nxt;
  logic [23:0]  ad_r, ad_nxt;
  sfw_wrap_type wrap_r, wrap_nxt;
  logic         cont_r, cont_nxt;
  logic         wel_r, wel_nxt;
  logic         busy_r, busy_nxt;
  logic [23:0]  tcnt_r, tcnt_nxt;
  logic [8:0]   walk_r, walk_nxt;
  logic [15:0]  pg_r, pg_nxt;
  logic [7:0]   pidx_r, pidx_nxt;
  logic         nd_r, nd_nxt;
  logic         ex_r, ex_nxt;
  logic [23:0]  ra_r, ra_nxt;
  logic         ract_r, ract_nxt;
  logic         rwr_r, rwr_nxt;
  logic [255:0] pv_r, pv_nxt;
  logic         bwe;
  logic [7:0]   b1, rmode, wm;
  logic [15:0]  l2;
  logic [23:0]  raddr;
  logic         rdone, isq;

  always_comb
  begin
    st_nxt = st_r;  gi_nxt = gi_r;  op_nxt = op_r;  ad_nxt = ad_r;
    wrap_nxt = wrap_r;  cont_nxt = cont_r;  wel_nxt = wel_r;
    busy_nxt = busy_r;  tcnt_nxt = tcnt_r;  walk_nxt = walk_r;
    pg_nxt = pg_r;  pidx_nxt = pidx_r;  nd_nxt = nd_r;  ex_nxt = ex_r;
    ra_nxt = ra_r;  ract_nxt = ract_r;  rwr_nxt = rwr_r;
    pv_nxt = pv_r;  bwe = 1'b0;  rdone = 1'b0;
    b1 = lane1(grp_r);
    isq = (op_r == OP_QRD) || (op_r == OP_QWRD);
    l2 = lane2(grp_r);
    raddr = isq ? grp_r[31:8] : {ad_r[23:8], l2[15:8]};
    rmode = isq ? grp_r[7:0] : l2[7:0];
    wm = (WRAP_BASE << wrap_r.len) - 8'h01;
    // A continuous frame opens straight with the address.
    if (fstart)
    begin
      st_nxt = cont_r ? ST_RDAD : ST_CMD;
      gi_nxt = 2'h0;
      nd_nxt = 1'b0;
      ex_nxt = 1'b0;
      if (!busy_r)
        pv_nxt = '0;
    end
    if (gev)
    begin
      gi_nxt = gi_r + 2'h1;
      case (st_r)
        ST_CMD:
        begin
          op_nxt = b1;
          st_nxt = ST_SKIP;
          if (!busy_r && (b1 == OP_QRD || b1 == OP_QWRD || b1 == OP_DRD))
            st_nxt = ST_RDAD;
          else if (!busy_r && b1 == OP_WRAP)
            st_nxt = ST_WRAP;
          else if (!busy_r && b1 == OP_PROG && wel_r)
            st_nxt = ST_PADR;
          gi_nxt = 2'h0;
        end
        ST_RDAD:
        begin
          // Quad needs one group for address and mode, dual two.
          if (isq || gi_r == 2'h1)
            rdone = 1'b1;
          else
            ad_nxt[23:8] = lane2(grp_r);
        end
        ST_WRAP:
        begin
          wrap_nxt = grp_r[WRAP_LSB +: 3];
          st_nxt = ST_SKIP;
        end
        ST_PADR:
        begin
          ad_nxt = {ad_r[15:0], b1};
          if (gi_r == 2'h2)
          begin
            st_nxt = ST_PDAT;
            pidx_nxt = b1;
          end
        end
        ST_PDAT:
        begin
          bwe = 1'b1;
          pv_nxt[pidx_r] = 1'b1;
          pidx_nxt = pidx_r + 8'h01;
          nd_nxt = 1'b1;
        end
        ST_SKIP:
          ex_nxt = 1'b1;
        default:
          st_nxt = ST_SKIP;
      endcase
    end
    // Mode pair 10 keeps the next frame opcode-free; anything else,
    // including the all-ones reset pattern, releases the mode.
    if (rdone)
    begin
      cont_nxt = rmode[CTL_LSB +: 2] == CTL_CONT;
      ra_nxt = raddr;
      ract_nxt = 1'b1;
      rwr_nxt = isq && !wrap_r.dis;
      st_nxt = ST_SKIP;
    end
    // Each data fetch advances; wrapped reads loop inside the aligned section.
    if (ract_r && rd_next)
    begin
      if (rwr_r)
        ra_nxt[7:0] = (ra_r[7:0] & ~wm) | ((ra_r[7:0] + 8'h01) & wm);
      else
        ra_nxt = ra_r + 24'h000001;
    end
    // Frame end: reads stop, clean byte-aligned commands execute.
    if (end_d2)
    begin
      ract_nxt = 1'b0;
      rwr_nxt = 1'b0;
      if (st_r == ST_PDAT && nd_r && al_s2)
      begin
        if (!prot_hit(ad_r[21:12], prot))
        begin
          busy_nxt = 1'b1;
          tcnt_nxt = 24'h000000;
          walk_nxt = 9'h000;
          pg_nxt = ad_r[23:8];
        end
      end
      if (st_r == ST_SKIP && !ex_r && al_s2 && !busy_r)
      begin
        if (op_r == OP_WREN)
          wel_nxt = 1'b1;
        if (op_r == OP_WRDI)
          wel_nxt = 1'b0;
      end
    end
    // Self-timed cycle: stream loaded bytes out, then drop busy.
    if (busy_r)
    begin
      if (!walk_r[8])
        walk_nxt = walk_r + 9'h001;
      tcnt_nxt = tcnt_r + 24'h000001;
      if (tcnt_r == 24'(TPP_CYC - 1))
      begin
        busy_nxt = 1'b0;
        wel_nxt = 1'b0;
      end
    end
  end

  // Registers, with power-on values for the mode and wrap state.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_r <= ST_CMD;  gi_r <= 2'h0;  op_r <= 8'h00;  ad_r <= 24'h000000;
      wrap_r <= WRAP_RST;
      cont_r <= 1'b0;
      wel_r <= 1'b0;  busy_r <= 1'b0;  tcnt_r <= 24'h000000;
      walk_r <= 9'h100;  pg_r <= 16'h0000;  pidx_r <= 8'h00;
      nd_r <= 1'b0;  ex_r <= 1'b0;  ra_r <= 24'h000000;
      ract_r <= 1'b0;  rwr_r <= 1'b0;  pv_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;  gi_r <= gi_nxt;  op_r <= op_nxt;  ad_r <= ad_nxt;
      wrap_r <= wrap_nxt;  cont_r <= cont_nxt;
      wel_r <= wel_nxt;  busy_r <= busy_nxt;  tcnt_r <= tcnt_nxt;
      walk_r <= walk_nxt;  pg_r <= pg_nxt;  pidx_r <= pidx_nxt;
      nd_r <= nd_nxt;  ex_r <= ex_nxt;  ra_r <= ra_nxt;
      ract_r <= ract_nxt;  rwr_r <= rwr_nxt;  pv_r <= pv_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Page buffer: later bytes at the same index overwrite earlier ones.
  logic [7:0]   pbuf [256];
  sfw_prog_type prog_r;

  always_ff @(posedge ref_clk)
  begin
    if (bwe)
      pbuf[pidx_r] <= b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      prog_r <= '0;
    else
    begin
      prog_r.we   <= busy_r && !walk_r[8] && pv_r[walk_r[7:0]];
      prog_r.addr <= {pg_r, walk_r[7:0]};
      prog_r.data <= pbuf[walk_r[7:0]];
    end
  end

  assign read_addr          = ra_r;
  assign read_active        = ract_r;
  assign read_wrap_on       = rwr_r;
  assign wrap_config_field  = wrap_r;
  assign cont_read_on       = cont_r;
  assign busy               = busy_r;
  assign write_enable_latch = wel_r;
  assign prog               = prog_r;
endmodule : sfw_cmd_core
`default_nettype wire

// >>> tb/sfw_cmd_core_props.sv
// Purpose: Port-level properties of the serial flash command core.
// Assumes: All watched outputs live in the ref_clk domain.
// Notes:   Attached to every core instance by the bind at the foot.
`default_nettype none
module sfw_cmd_core_props
  import sfw_pkg::*;
#(
  parameter int TPP_US = 1000
)(
  input wire logic                  ref_clk,
  input wire logic                  reset,
  input wire logic                  rd_next,
  input wire logic [23:0]           read_addr,
  input wire logic                  read_active,
  input wire logic                  read_wrap_on,
  input wire logic [2:0]            wrap_config_field,
  input wire logic                  cont_read_on,
  input wire logic                  busy,
  input wire logic                  write_enable_latch,
  input wire sfw_pkg::sfw_prog_type prog
);
  localparam int TPP_CYC = TPP_US * CLK_MHZ;
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  // Busy run length; a cycle that is cut short or overruns shows at the fall.
  always_comb busy_cnt_nxt = busy ? busy_cnt_r + 32'h1 : 32'h0;
  always_ff @(posedge ref_clk) busy_cnt_r <= reset ? 32'h0 : busy_cnt_nxt;
  chk_reset_vals: assert property (
    $fell(reset) |-> wrap_config_field == WRAP_RST && !cont_read_on && !busy)
    else $error("state after reset wrong");
  chk_busy_len: assert property (
    $fell(busy) |-> busy_cnt_r >= TPP_CYC && busy_cnt_r <= TPP_CYC + 1)
    else $error("program cycle length wrong");
  chk_latch_clear: assert property (
    $fell(busy) |-> !write_enable_latch)
    else $error("latch kept after program cycle");
  chk_busy_latch: assert property (
    $rose(busy) |-> write_enable_latch)
    else $error("program cycle without latch");
  chk_we_busy: assert property (
    prog.we |-> busy)
    else $error("byte load outside program cycle");
  chk_we_order: assert property (
    prog.we && $past(prog.we) |-> prog.addr[23:8] == $past(prog.addr[23:8])
      && prog.addr[7:0] > $past(prog.addr[7:0]))
    else $error("byte loads leave page or order");
  chk_wrap_step: assert property (
    rd_next && read_active && read_wrap_on |=> read_addr != $past(read_addr)
      && read_addr[23:8] == $past(read_addr[23:8]) && ((read_addr[7:0]
      ^ $past(read_addr[7:0])) >> ($past(wrap_config_field[2:1]) + 3)) == 8'h0)
    else $error("wrapped step leaves section");
  chk_lin_step: assert property (
    rd_next && read_active && !read_wrap_on |=> read_addr == $past(read_addr) + 24'h1)
    else $error("linear step wrong");
  chk_wrap_gate: assert property (
    read_wrap_on |-> read_active && !wrap_config_field[0])
    else $error("wrap on while disabled");
  chk_cont_rise: assert property (
    $rose(cont_read_on) |-> read_active)
    else $error("continuous mode outside a read");
  cover property ($fell(busy));
  cover property (rd_next && read_wrap_on);
  cover property ($fell(cont_read_on));
endmodule : sfw_cmd_core_props
bind sfw_cmd_core sfw_cmd_core_props #(.TPP_US(TPP_US)) u_props (
  .ref_clk(ref_clk), .reset(reset), .rd_next(rd_next), .read_addr(read_addr),
  .read_active(read_active), .read_wrap_on(read_wrap_on),
  .wrap_config_field(wrap_config_field), .cont_read_on(cont_read_on), .busy(busy),
  .write_enable_latch(write_enable_latch), .prog(prog));
`default_nettype wire

// >>> tb/sfw_host_model.sv
// Purpose: Behavioural host controller driving the flash serial link.
// Assumes: Serial clock of 12 ns, idle low, stopped between frames.
// Notes:   Released data lines show the inverse of their last value.
`default_nettype none
module sfw_host_model (
  output logic       cs_n,
  output logic       spi_clk,
  output logic [3:0] io_in
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  // Idle link: deselected, clock parked low.
  initial
  begin
    cs_n <= 1'b1;
    spi_clk = 1'b0;
    io_in = 4'h0;
  end
  // Select the device; data leads the first rise by half a period.
  task automatic open();
    cs_n = 1'b0;
    #6;
  endtask : open
  // Shift n bits MSB first, w lines a clock, data changed after each fall.
  task automatic put(input logic [35:0] v, input int n, input int w);
    for (int i = n - w; i >= 0; i -= w)
    begin
      io_in = v[i +: 4];
      #6 spi_clk = 1'b1;
      #6 spi_clk = 1'b0;
    end
  endtask : put
  // Deselect right after the last fall, then keep the gap between frames.
  task automatic close();
    #2 cs_n = 1'b1;
    io_in = ~io_in;
    #20;
  endtask : close
endmodule : sfw_host_model
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench of the serial flash command core.
// Assumes: Host model drives the link; program time cut to 2 us.
// Notes:   Expected values come from the small model in the tasks below.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sfw_pkg::*;
  logic            ref_clk = 1'b0;
  logic            reset   = 1'b0;
  logic            rd_next = 1'b0;
  sfw_prot_type    prot    = '0;
  wire logic       cs_n;
  wire logic       spi_clk;
  wire logic [3:0] io_in;
  logic [23:0]     read_addr;
  logic            read_active;
  logic            read_wrap_on;
  logic [2:0]      wrap_config_field;
  logic            cont_read_on;
  logic            busy;
  logic            write_enable_latch;
  sfw_prog_type    prog;
  int              fails = 0;
  int              n_checks = 0;
  int              cyc = 0;
  int              n;
  logic [7:0]      img [256];
  bit              hit [256];
  logic [31:0]     got [$];
  logic [31:0]     r;
  logic [23:0]     a;
  ////////////////////////////////////////////////////////////
  sfw_host_model i_host (.cs_n(cs_n), .spi_clk(spi_clk), .io_in(io_in));
  sfw_cmd_core #(.TPP_US(2)) i_dut (
    .ref_clk(ref_clk), .reset(reset), .spi_clk(spi_clk), .cs_n(cs_n), .io_in(io_in),
    .prot(prot), .rd_next(rd_next), .read_addr(read_addr), .read_active(read_active),
    .read_wrap_on(read_wrap_on), .wrap_config_field(wrap_config_field),
    .cont_read_on(cont_read_on), .busy(busy), .write_enable_latch(write_enable_latch),
    .prog(prog));
  // 250 MHz clock and a hang limit well above the expected run.
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      close_out();
    end
  end
  // Every byte handed to the array, in the order the core emits them.
  always @(posedge ref_clk)
    if (prog.we === 1'b1)
      got.push_back({prog.addr, prog.data});
  task automatic tk(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : tk
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %0t %s", $time, s);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // Frame helpers; the settle time covers the core's frame-end latency.
  task automatic cmd(input logic [7:0] op);
    i_host.open();
    i_host.put(op, 8, 1);
    i_host.close();
    tk(8);
  endtask : cmd
  task automatic ones(input int w);
    i_host.open();
    i_host.put(36'hFFFFFFFF, 32, w);
    i_host.close();
    tk(8);
  endtask : ones
  task automatic set_wrap(input logic [7:0] w);
    i_host.open();
    i_host.put(OP_WRAP, 8, 1);
    i_host.put({r[23:0], w}, 32, 4);
    i_host.close();
    tk(8);
  endtask : set_wrap
  task automatic rd(input bit op_on, input logic [7:0] op, input logic [7:0] md, input int w);
    i_host.open();
    if (op_on)
      i_host.put(op, 8, 1);
    i_host.put({a, md}, 32, w);
    tk(8);
  endtask : rd
  task automatic step(input int len, input bit wr, input int k);
    logic [23:0] e;
    logic [7:0]  msk;
    e = a;
    msk = 8'((8 << len) - 1);
    repeat (k)
    begin
      rd_next <= 1'b1;
      tk(1);
      rd_next <= 1'b0;
      tk(1);
      e = wr ? {e[23:8], (e[7:0] & ~msk) | ((e[7:0] + 8'h1) & msk)} : e + 24'h1;
      chk(read_addr, e, "read step");
    end
    i_host.close();
    tk(8);
  endtask : step
  task automatic pgm(input logic [23:0] pa, input int k, input int extra);
    logic [7:0] d;
    i_host.open();
    i_host.put(OP_PROG, 8, 1);
    i_host.put(pa, 24, 1);
    repeat (k)
    begin
      d = 8'($urandom);
      i_host.put(d, 8, 1);
      img[pa[7:0]] = d;
      hit[pa[7:0]] = 1'b1;
      pa[7:0] = pa[7:0] + 8'h1;
    end
    if (extra > 0)
      i_host.put(36'h0, extra, 1);
    i_host.close();
    tk(8);
  endtask : pgm
  // Main sequence.
  initial
  begin
    reset <= 1'b1;
    r = $urandom(1);
    tk(5);
    reset <= 1'b0;
    tk(2);
    chk(wrap_config_field, WRAP_RST, "wrap after reset");
    chk({cont_read_on, busy, write_enable_latch}, 0, "flags after reset");
    ones(4);
    set_wrap({r[7:5], 1'b1, r[3:0]});
    for (int len = 0; len < 4; len++)
    begin
      r = $urandom;
      a = {r[31:9], 1'b0};
      set_wrap({r[7], 2'(len), 1'b0, r[3:0]});
      chk(wrap_config_field, {2'(len), 1'b0}, "wrap field");
      rd(1, len[0] ? OP_QWRD : OP_QRD, {r[7:6], CTL_CONT, r[3:0]}, 4);
      chk({read_active, read_wrap_on, cont_read_on}, 3'h7, "quad read flags");
      chk(read_addr, a, "read start");
      step(len, 1, (8 << len) + 2);
      a = a ^ 24'h010100;
      rd(0, 8'h00, {r[5:4], len[0] ? {len[1], len[1]} : CTL_CONT, r[3:0]}, 4);
      chk(read_addr, a, "opcode-free read");
      step(len, 1, 1);
      if (!len[0])
        ones(4);
      chk(cont_read_on, 0, "continuous mode left");
    end
    rd(1, OP_DRD, {r[7:6], CTL_CONT, r[3:0]}, 2);
    chk({read_active, read_wrap_on, cont_read_on}, 3'h5, "dual read flags");
    step(0, 0, 1);
    ones(2);
    chk(cont_read_on, 0, "dual continuous left");
    set_wrap({r[7:5], 1'b1, r[3:0]});
    a = {r[31:8], 8'hFE};
    rd(1, OP_QRD, 8'h00, 4);
    chk(read_wrap_on, 0, "wrap disabled");
    step(0, 0, 4);
    pgm(a, 2, 0);
    chk(busy, 0, "program without latch");
    ones(1);
    cmd(OP_WREN);
    chk(write_enable_latch, 1, "latch set");
    pgm(a, 2, 4);
    chk({busy, write_enable_latch}, 2'h1, "ragged deselect");
    prot <= '{cmp: 1'b1, sec: 1'b0, tb: 1'b0, bp: 3'h0};
    pgm(a, 2, 0);
    chk({busy, write_enable_latch}, 2'h1, "protected page");
    prot <= '0;
    hit = '{default: 1'b0};
    got.delete();
    pgm(a, 3, 0);
    chk(busy, 1, "program cycle running");
    for (int i = 0; i < 700 && busy !== 1'b0; i++)
      tk(1);
    chk({busy, write_enable_latch}, 2'h0, "program cycle end");
    n = 0;
    foreach (hit[i])
      if (hit[i])
      begin
        chk(got[n], {a[23:8], 8'(i), img[i]}, "program byte");
        n++;
      end
    chk(got.size(), n, "program byte count");
    cmd(OP_WREN);
    chk(write_enable_latch, 1, "latch set again");
    cmd(OP_WRDI);
    chk(write_enable_latch, 0, "latch cleared");
    close_out();
  end
endmodule : testbench
`default_nettype wire
